// *** core/rftc_core.v ***
`timescale 1ns/1ns
`include "rftc_map.vh"
module rftc_core #(
   parameter [63:0] UNIQUE_ADDR     = 64'h0123456789ABCDEF,     // arbitrary value
   parameter        HIGH_POWER      = 1'b0,                     // high-power variant
   parameter        ACK_CYC         = (`RFTC_ACK_MS * 1000000) / `RFTC_CLK_NS,
   parameter        RETRY_UNIT_CYC  = ((`RFTC_RETRY_MAX_MS * 1000000) / `RFTC_CLK_NS) >> `RFTC_RAND_RETRY_BITS,
   parameter        HOLD_UNIT_CYC   = (`RFTC_HOLD_UNIT_MS * 1000000) / `RFTC_CLK_NS,
   parameter        SCAN_UNIT_CYC   = `RFTC_SCAN_UNIT_NS / `RFTC_CLK_NS,
   parameter        BACKOFF_CYC     = `RFTC_BACKOFF_NS / `RFTC_CLK_NS,
   parameter        CHAR_CYC        = `RFTC_CHAR_NS / `RFTC_CLK_NS
) (
   input  wire        clk,               // 100 MHz
   input  wire        rst_n,             // synchronous reset
   input  wire        cfg_wr,            // parameter write strobe
   input  wire        cfg_rd,            // parameter read strobe
   input  wire [3:0]  cfg_idx,           // parameter index
   input  wire [31:0] cfg_wdata,         // write value
   output reg  [31:0] cfg_rdata,         // read value, one cycle after cfg_rd
   input  wire        rx_valid,          // serial byte received
   input  wire [7:0]  rx_byte,           // serial byte
   output wire        rx_ready,          // buffer can accept a byte
   output reg  [6:0]  tx_len,            // bytes in packet being sent
   input  wire [6:0]  tx_rd_addr,        // radio reads packet byte
   output reg  [7:0]  tx_rd_data,        // byte, one cycle later
   input  wire        cca_clear,         // channel clear
   output reg         rf_send,           // start one radio send
   output reg         rf_ack_req,        // ack request bit in header
   input  wire        rf_done,           // radio send finished
   input  wire        rf_purged,         // send purged by sleep coordinator
   input  wire        ack_rx,            // acknowledgement received
   output reg         tx_ok,             // packet delivered
   output reg         tx_drop,           // packet dropped
   input  wire        rx_pkt,            // radio packet received
   input  wire [7:0]  rx_db,             // dB above sensitivity, zero at or below
   output reg         pwm_out,           // rssi pwm
   input  wire        scan_req,          // commanded or association scan
   input  wire        scan_energy,       // energy scan when high
   input  wire        coord_start,       // coordinator startup
   input  wire        reassign_network_id_option, // coordinator option
   input  wire        reassign_channel_option,    // coordinator option
   output reg         scan_busy,         // scan running
   output reg         scan_is_energy,    // running scan is energy scan
   output reg  [7:0]  scan_channel,      // channel being scanned
   output reg         scan_done,         // scan finished pulse
   output wire        low_power_allow    // sleep may be entered
);
   localparam S_IDLE = 6'b000001;
   localparam S_BOFF = 6'b000010;
   localparam S_CCA  = 6'b000100;
   localparam S_SEND = 6'b001000;
   localparam S_ACK  = 6'b010000;
   localparam S_RDLY = 6'b100000;
   localparam PWM_STEP_CYC = `RFTC_PWM_STEP_NS / `RFTC_CLK_NS;
   // first set channel at or above position from; 16 when none
   function [4:0] next_chan;
      input [15:0] mask;
      input [4:0]  from;
      integer      i;
      begin
         next_chan = 5'h10;
         for (i = 15; i >= 0; i = i - 1) begin
            if (mask[i] && i >= from)
               next_chan = i[4:0];
         end
      end
   endfunction

   reg [7:0]  min_be_reg, gap_reg, hold_reg, retry_reg, sd_reg, sleep_reg;
   reg [15:0] mask_reg, dest_lo_reg;
   reg [15:0] lfsr_reg;

   always @(posedge clk) begin
      if (!rst_n) begin
         min_be_reg  <= `RFTC_RST_MIN_BE;
         gap_reg     <= `RFTC_RST_GAP;
         hold_reg    <= `RFTC_RST_HOLD;
         retry_reg   <= `RFTC_RST_RETRY;
         mask_reg    <= `RFTC_RST_MASK & (HIGH_POWER ? ~`RFTC_HP_MASK_BAN : 16'hFFFF);
         sd_reg      <= `RFTC_RST_SD;
         sleep_reg   <= `RFTC_RST_SLEEP;
         dest_lo_reg <= `RFTC_RST_DEST_LO;
         cfg_rdata   <= 32'h0;
      end else begin
         if (cfg_wr) begin
            case (cfg_idx)
               `RFTC_IDX_MIN_BE: if (cfg_wdata[7:0] <= `RFTC_MAX_MIN_BE) min_be_reg <= cfg_wdata[7:0];
               `RFTC_IDX_GAP:    gap_reg <= cfg_wdata[7:0];
               `RFTC_IDX_HOLD:   hold_reg <= cfg_wdata[7:0];
               `RFTC_IDX_RETRY:  if (cfg_wdata[7:0] <= `RFTC_MAX_RETRY) retry_reg <= cfg_wdata[7:0];
               `RFTC_IDX_MASK:   mask_reg <= cfg_wdata[15:0] & (HIGH_POWER ? ~`RFTC_HP_MASK_BAN : 16'hFFFF);
               `RFTC_IDX_SD:     if (cfg_wdata[7:0] <= `RFTC_MAX_SD) sd_reg <= cfg_wdata[7:0];
               `RFTC_IDX_SLEEP:  sleep_reg <= cfg_wdata[7:0];
               `RFTC_IDX_DEST_LO: dest_lo_reg <= cfg_wdata[15:0];
               default: ; // address words ignore writes
            endcase
         end
         if (cfg_rd) begin
            case (cfg_idx)
               `RFTC_IDX_MIN_BE:  cfg_rdata <= {24'h0, min_be_reg};
               `RFTC_IDX_GAP:     cfg_rdata <= {24'h0, gap_reg};
               `RFTC_IDX_HOLD:    cfg_rdata <= {24'h0, hold_reg};
               `RFTC_IDX_RETRY:   cfg_rdata <= {24'h0, retry_reg};
               `RFTC_IDX_MASK:    cfg_rdata <= {16'h0, mask_reg};
               `RFTC_IDX_SD:      cfg_rdata <= {24'h0, sd_reg};
               `RFTC_IDX_ADDR_HI: cfg_rdata <= UNIQUE_ADDR[63:32];
               `RFTC_IDX_ADDR_LO: cfg_rdata <= UNIQUE_ADDR[31:0];
               `RFTC_IDX_SLEEP:   cfg_rdata <= {24'h0, sleep_reg};
               `RFTC_IDX_DEST_LO: cfg_rdata <= {16'h0, dest_lo_reg};
               default:           cfg_rdata <= 32'h0;
            endcase
         end
      end
   end

   // awake whenever sleep is not selected; no sleep state machine here
   assign low_power_allow = (sleep_reg != `RFTC_RST_SLEEP);

   // runs every cycle regardless of traffic, so nodes decorrelate
   always @(posedge clk) begin
      if (!rst_n)
         lfsr_reg <= `RFTC_LFSR_SEED;
      else
         lfsr_reg <= lfsr_reg[0] ? ((lfsr_reg >> 1) ^ `RFTC_LFSR_TAPS) : (lfsr_reg >> 1);
   end
   reg  [7:0]  buf_mem [0:99];
   reg  [6:0]  cnt_reg;
   reg  [31:0] char_pre_reg;
   reg  [7:0]  silent_reg;
   reg         pend_reg;
   reg  [5:0]  state_reg;
   wire        take = rx_valid && rx_ready;
   wire        fire = !pend_reg && state_reg == S_IDLE && cnt_reg != 7'h0 &&
                      (gap_reg == 8'h0 || silent_reg >= gap_reg || cnt_reg == `RFTC_PKT_MAX);
   wire        fin;
   // bytes wait while a packet is in flight or launching, else a byte taken on the launch edge is lost
   assign rx_ready = !pend_reg && !fire && cnt_reg != `RFTC_PKT_MAX;
   always @(posedge clk) begin
      if (take)
         buf_mem[cnt_reg] <= rx_byte;
      tx_rd_data <= buf_mem[tx_rd_addr];
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         cnt_reg      <= 7'h0;
         char_pre_reg <= 32'h0;
         silent_reg   <= 8'h0;
         pend_reg     <= 1'b0;
         tx_len       <= 7'h0;
      end else begin
         if (take) begin
            cnt_reg      <= cnt_reg + 7'h1;
            char_pre_reg <= 32'h0;
            silent_reg   <= 8'h0;
         end else if (cnt_reg != 7'h0 && silent_reg != 8'hFF) begin
            if (char_pre_reg == CHAR_CYC - 1) begin
               char_pre_reg <= 32'h0;
               silent_reg   <= silent_reg + 8'h1;
            end else
               char_pre_reg <= char_pre_reg + 32'h1;
         end
         if (fire) begin
            pend_reg <= 1'b1;
            tx_len   <= cnt_reg;
         end else if (fin) begin
            pend_reg   <= 1'b0;
            cnt_reg    <= 7'h0;
            silent_reg <= 8'h0;
         end
      end
   end
   reg  [2:0]  be_reg, nb_reg;
   reg  [7:0]  app_left_reg;
   reg         bcast_reg;
   reg  [31:0] pre_reg, pre_len_reg;
   reg  [15:0] units_reg;
   wire        tick = (pre_reg == pre_len_reg - 1);
   wire [15:0] rand_be = lfsr_reg & ((16'h1 << be_reg) - 16'h1);
   wire [15:0] rand_first = lfsr_reg & ((16'h1 << min_be_reg[2:0]) - 16'h1);
   assign fin = tx_ok || tx_drop;
   always @(posedge clk) begin
      if (!rst_n) begin
         state_reg    <= S_IDLE;
         be_reg       <= 3'h0;
         nb_reg       <= 3'h0;
         app_left_reg <= 8'h0;
         bcast_reg    <= 1'b0;
         pre_reg      <= 32'h0;
         pre_len_reg  <= 32'h1;
         units_reg    <= 16'h0;
         rf_send      <= 1'b0;
         rf_ack_req   <= 1'b0;
         tx_ok        <= 1'b0;
         tx_drop      <= 1'b0;
      end else begin
         rf_send <= 1'b0;
         tx_ok   <= 1'b0;
         tx_drop <= 1'b0;
         case (state_reg)
            S_IDLE: if (pend_reg && !fin) begin
               bcast_reg  <= (dest_lo_reg == `RFTC_BCAST);
               rf_ack_req <= (dest_lo_reg != `RFTC_BCAST) && retry_reg != 8'h0;
               // broadcast repeats: none, or retries plus one more
               if (dest_lo_reg == `RFTC_BCAST)
                  app_left_reg <= (retry_reg == 8'h0) ? 8'h0 : retry_reg + 8'h1;
               else
                  app_left_reg <= retry_reg;
               be_reg      <= min_be_reg[2:0];
               nb_reg      <= 3'h0;
               pre_reg     <= 32'h0;
               pre_len_reg <= BACKOFF_CYC;
               units_reg   <= rand_first; // zero when exponent is zero
               state_reg   <= S_BOFF;
            end
            S_BOFF, S_ACK, S_RDLY: begin
               if (state_reg == S_ACK && ack_rx) begin
                  tx_ok     <= 1'b1;
                  state_reg <= S_IDLE;
               end else if (units_reg == 16'h0) begin
                  if (state_reg == S_ACK) begin
                     if (app_left_reg != 8'h0) begin
                        app_left_reg <= app_left_reg - 8'h1;
                        pre_len_reg  <= RETRY_UNIT_CYC;
                        units_reg    <= {4'h0, lfsr_reg[`RFTC_RAND_RETRY_BITS-1:0]};
                        state_reg    <= S_RDLY;
                     end else begin
                        tx_drop   <= 1'b1;
                        state_reg <= S_IDLE;
                     end
                  end else if (state_reg == S_RDLY) begin
                     be_reg      <= min_be_reg[2:0];
                     nb_reg      <= 3'h0;
                     pre_len_reg <= BACKOFF_CYC;
                     units_reg   <= rand_first;
                     state_reg   <= S_BOFF;
                  end else
                     state_reg <= S_CCA;
                  pre_reg <= 32'h0;
               end else if (tick) begin
                  pre_reg   <= 32'h0;
                  units_reg <= units_reg - 16'h1;
               end else
                  pre_reg <= pre_reg + 32'h1;
            end
            S_CCA: begin
               if (cca_clear) begin
                  rf_send   <= 1'b1;
                  state_reg <= S_SEND;
               end else if (nb_reg == `RFTC_MAC_TRIES - 3'h1) begin
                  tx_drop   <= 1'b1;
                  state_reg <= S_IDLE;
               end else begin
                  nb_reg    <= nb_reg + 3'h1;
                  be_reg    <= (be_reg == `RFTC_MAX_BE) ? be_reg : be_reg + 3'h1;
                  units_reg <= (be_reg == `RFTC_MAX_BE) ? rand_be : lfsr_reg & ((16'h2 << be_reg) - 16'h1);
                  state_reg <= S_BOFF;
               end
            end
            S_SEND: if (rf_done) begin
               if (rf_purged) begin
                  tx_drop   <= 1'b1;
                  state_reg <= S_IDLE;
               end else if (bcast_reg) begin
                  if (app_left_reg != 8'h0) begin
                     app_left_reg <= app_left_reg - 8'h1;
                     nb_reg       <= 3'h0;
                     be_reg       <= min_be_reg[2:0];
                     pre_len_reg  <= BACKOFF_CYC;
                     units_reg    <= rand_first;
                     state_reg    <= S_BOFF;
                  end else begin
                     tx_ok     <= 1'b1;
                     state_reg <= S_IDLE;
                  end
               end else if (rf_ack_req) begin
                  pre_reg     <= 32'h0;
                  pre_len_reg <= ACK_CYC;
                  units_reg   <= 16'h1;
                  state_reg   <= S_ACK;
               end else begin
                  tx_ok     <= 1'b1;
                  state_reg <= S_IDLE;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end
   reg  [3:0]  step_pre_reg;
   reg  [8:0]  pos_reg, duty_reg;
   reg         act_reg;
   reg  [31:0] hold_pre_reg;
   reg  [7:0]  hold_cnt_reg;
   wire [19:0] db_scaled = rx_db * `RFTC_DUTY_SLOPE;
   wire [11:0] duty_raw = {3'b0, `RFTC_DUTY_FLOOR} + db_scaled[19:8];
   always @(posedge clk) begin
      if (!rst_n) begin
         step_pre_reg <= 4'h0;
         pos_reg      <= 9'h0;
         duty_reg     <= 9'h0;
         act_reg      <= 1'b0;
         hold_pre_reg <= 32'h0;
         hold_cnt_reg <= 8'h0;
         pwm_out      <= 1'b0;
      end else begin
         if (step_pre_reg == PWM_STEP_CYC - 1) begin
            step_pre_reg <= 4'h0;
            pos_reg      <= (pos_reg == `RFTC_PWM_STEPS - 9'd1) ? 9'h0 : pos_reg + 9'h1;
         end else
            step_pre_reg <= step_pre_reg + 4'h1;
         if (rx_pkt) begin
            duty_reg     <= (duty_raw > {3'b0, `RFTC_PWM_STEPS}) ? `RFTC_PWM_STEPS : duty_raw[8:0];
            act_reg      <= (hold_reg != 8'h0);
            hold_pre_reg <= 32'h0;
            hold_cnt_reg <= hold_reg;
         end else if (act_reg && hold_reg != `RFTC_HOLD_FOREVER) begin
            if (hold_cnt_reg == 8'h0)
               act_reg <= 1'b0;
            else if (hold_pre_reg == HOLD_UNIT_CYC - 1) begin
               hold_pre_reg <= 32'h0;
               hold_cnt_reg <= hold_cnt_reg - 8'h1;
            end else
               hold_pre_reg <= hold_pre_reg + 32'h1;
         end
         pwm_out <= act_reg && (pos_reg < duty_reg);
      end
   end
   reg  [4:0]  chan_reg;
   reg  [31:0] scan_pre_reg;
   reg  [16:0] scan_units_reg;
   wire        coord_scan = coord_start && (reassign_network_id_option || reassign_channel_option);
   wire [4:0]  first_chan = next_chan(mask_reg, 5'h0);
   wire [4:0]  after_chan = next_chan(mask_reg, chan_reg + 5'h1);
   always @(posedge clk) begin
      if (!rst_n) begin
         scan_busy      <= 1'b0;
         scan_is_energy <= 1'b0;
         scan_channel   <= 8'h0;
         scan_done      <= 1'b0;
         chan_reg       <= 5'h0;
         scan_pre_reg   <= 32'h0;
         scan_units_reg <= 17'h0;
      end else begin
         scan_done <= 1'b0;
         if (!scan_busy) begin
            if (scan_req || coord_scan) begin
               // network search wins when both coordinator options are set
               scan_is_energy <= coord_scan ? !reassign_network_id_option : scan_energy;
               if (first_chan[4])
                  scan_done <= 1'b1;
               else begin
                  scan_busy    <= 1'b1;
                  chan_reg     <= first_chan;
                  scan_channel <= `RFTC_CHAN_BASE + {4'h0, first_chan[3:0]};
               end
               scan_pre_reg   <= 32'h0;
               scan_units_reg <= 17'h0;
            end
         end else if (scan_pre_reg == SCAN_UNIT_CYC - 1) begin
            scan_pre_reg <= 32'h0;
            if (scan_units_reg == (17'h1 << sd_reg[3:0]) - 17'h1) begin
               scan_units_reg <= 17'h0;
               if (chan_reg == 5'hF || after_chan[4]) begin
                  scan_busy <= 1'b0;
                  scan_done <= 1'b1;
               end else begin
                  chan_reg     <= after_chan;
                  scan_channel <= `RFTC_CHAN_BASE + {4'h0, after_chan[3:0]};
               end
            end else
               scan_units_reg <= scan_units_reg + 17'h1;
         end else
            scan_pre_reg <= scan_pre_reg + 32'h1;
      end
   end
endmodule // rftc_core

// *** core/rftc_map.vh ***
`ifndef RFTC_MAP_VH
`define RFTC_MAP_VH
// parameter indices on the configuration port
`define RFTC_IDX_MIN_BE      4'h0
`define RFTC_IDX_GAP         4'h1
`define RFTC_IDX_HOLD        4'h2
`define RFTC_IDX_RETRY       4'h3
`define RFTC_IDX_MASK        4'h4
`define RFTC_IDX_SD          4'h5
`define RFTC_IDX_ADDR_HI     4'h6
`define RFTC_IDX_ADDR_LO     4'h7
`define RFTC_IDX_SLEEP       4'h8
`define RFTC_IDX_DEST_LO     4'h9
// reset values and limits
`define RFTC_RST_MIN_BE      8'h00
`define RFTC_RST_GAP         8'h03
`define RFTC_RST_HOLD        8'h28
`define RFTC_RST_RETRY       8'h00
`define RFTC_RST_MASK        16'h1FFE
`define RFTC_RST_SD          8'h04
`define RFTC_RST_SLEEP       8'h00
`define RFTC_RST_DEST_LO     16'h0000
`define RFTC_MAX_MIN_BE      8'h03
`define RFTC_MAX_RETRY       8'h06
`define RFTC_MAX_SD          8'h0F
`define RFTC_MAX_BE          3'h5
`define RFTC_MAC_TRIES       3'h4
`define RFTC_HOLD_FOREVER    8'hFF
`define RFTC_BCAST           16'hFFFF
`define RFTC_HP_MASK_BAN     16'hC001
`define RFTC_CHAN_BASE       8'h0B
`define RFTC_PKT_MAX         7'h64
`define RFTC_RAND_RETRY_BITS 12
`define RFTC_LFSR_SEED       16'hACE1
`define RFTC_LFSR_TAPS       16'hB400
// timing, each in its own unit
`define RFTC_CLK_NS          10
`define RFTC_ACK_MS          200
`define RFTC_RETRY_MAX_MS    48
`define RFTC_HOLD_UNIT_MS    100
`define RFTC_SCAN_UNIT_NS    15360000
`define RFTC_BACKOFF_NS      320000
`define RFTC_PWM_STEPS       9'd445
`define RFTC_PWM_STEP_NS     144
`define RFTC_CHAR_NS         1041670
// rssi to duty: 24 % floor, about 7.6 steps per dB
`define RFTC_DUTY_FLOOR      9'd107
`define RFTC_DUTY_SLOPE      12'h791
`endif

// *** testbench/rftc_chk_assertions.sv ***
`timescale 1ns/1ns
module rftc_chk #(
   parameter [63:0] UNIQUE_ADDR = 64'h0
) (
   input wire        clk,             // clock
   input wire        rst_n,           // reset
   input wire        cfg_wr,          // write
   input wire        cfg_rd,          // read
   input wire [3:0]  cfg_idx,         // index
   input wire [31:0] cfg_wdata,       // write value
   input wire [31:0] cfg_rdata,       // read value
   input wire        rx_ready,        // byte accept
   input wire        cca_clear,       // channel clear
   input wire        rf_send,         // send start
   input wire        tx_ok,           // delivered
   input wire        tx_drop,         // dropped
   input wire        rx_pkt,          // packet in
   input wire        pwm_out,         // rssi pwm
   input wire        low_power_allow  // sleep allowed
);
   reg seen_pkt;
   always @(posedge clk) begin
      if (!rst_n) seen_pkt <= 1'b0;
      else if (rx_pkt) seen_pkt <= 1'b1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_addr_hi; cfg_rd && cfg_idx == 4'h6 |=> cfg_rdata == UNIQUE_ADDR[63:32]; endproperty
   a_addr_hi: assert property (p_addr_hi) else $error("high address word wrong");
   property p_addr_lo; cfg_rd && cfg_idx == 4'h7 |=> cfg_rdata == UNIQUE_ADDR[31:0]; endproperty
   a_addr_lo: assert property (p_addr_lo) else $error("low address word wrong");
   property p_unmapped; cfg_rd && cfg_idx > 4'h9 |=> cfg_rdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped index not zero");
   property p_pwm_init; !seen_pkt |-> !pwm_out; endproperty
   a_pwm_init: assert property (p_pwm_init) else $error("pwm high before first packet");
   property p_send; rf_send |-> $past(cca_clear); endproperty
   a_send: assert property (p_send) else $error("send without clear channel");
   property p_ready; tx_ok || tx_drop |=> rx_ready; endproperty
   a_ready: assert property (p_ready) else $error("buffer not freed after packet");
   property p_sleep; cfg_wr && cfg_idx == 4'h8 |=> low_power_allow == (($past(cfg_wdata) & 32'hFF) != 0); endproperty
   a_sleep: assert property (p_sleep) else $error("sleep allow wrong");
   property p_excl; !(tx_ok && tx_drop); endproperty
   a_excl: assert property (p_excl) else $error("packet both sent and dropped");
endmodule // rftc_chk
bind rftc_core rftc_chk #(.UNIQUE_ADDR(UNIQUE_ADDR)) i_rftc_chk (.*);

// *** testbench/rftc_radio_model.sv ***
`timescale 1ns/1ns
module rftc_radio_model (
   input  wire       clk,             // clock
   input  wire       rf_send,         // send start
   input  wire       rf_ack_req,      // ack request
   input  wire [6:0] tx_len,          // length
   input  wire       cca_busy,        // channel held busy
   input  wire       ack_en,          // peer answers
   output wire       cca_clear,       // channel clear
   output reg        rf_done = 1'b0,  // send over
   output reg        ack_rx = 1'b0,   // ack pulse
   output int        n_send = 0,      // sends seen
   output reg  [6:0] last_len = 7'h0, // length sent
   output reg        last_ack = 1'b0  // ack bit sent
);
   reg [7:0] sr = 8'h00;
   assign cca_clear = !cca_busy;
   always @(posedge clk) begin
      sr <= {sr[6:0], rf_send};
      rf_done <= sr[2];
      // peer acknowledges only packets that asked for it
      ack_rx <= sr[7] && ack_en && last_ack;
      if (rf_send) begin
         n_send <= n_send + 1;
         last_len <= tx_len;
         last_ack <= rf_ack_req;
      end
   end
endmodule // rftc_radio_model

// *** testbench/testbench.sv ***
`timescale 1ns/1ns
module testbench;
   localparam [63:0] UA = 64'h0F1E2D3C4B5A6978; // arbitrary value
   logic clk = 0, rst_n = 0, cfg_wr = 0, cfg_rd = 0, rx_valid = 0, rf_purged = 0, rx_pkt = 0, scan_req = 0;
   logic scan_energy = 0, coord_start = 0, reassign_network_id_option = 0, reassign_channel_option = 0;
   logic cca_busy = 0, ack_en = 0, rd_seen = 0;
   logic [3:0] cfg_idx = 0;
   logic [31:0] cfg_wdata = 0;
   logic [7:0] rx_byte = 0, rx_db = 0;
   logic [6:0] tx_rd_addr = 0;
   wire [31:0] cfg_rdata;
   wire [7:0] tx_rd_data, scan_channel;
   wire [6:0] tx_len, last_len;
   wire rx_ready, cca_clear, rf_send, rf_ack_req, rf_done, ack_rx, tx_ok, tx_drop, pwm_out, last_ack;
   wire scan_busy, scan_is_energy, scan_done, low_power_allow;
   int n_send, n_fail = 0, comparisons = 0, h, s, t;
   logic [31:0] q_rd[$];
   logic [1:0] q_pkt[$];
   logic [31:0] rv[10] = '{0, 3, 32'h28, 0, 32'h1FFE, 4, UA[63:32], UA[31:0], 0, 0};
   logic [3:0] bi[3] = '{0, 3, 5};
   logic [31:0] bv[3] = '{4, 7, 16};
   logic [31:0] gv[3] = '{3, 6, 15};
   logic [7:0] ch, sent[100];
   rftc_core #(.UNIQUE_ADDR(UA), .ACK_CYC(20), .RETRY_UNIT_CYC(2), .HOLD_UNIT_CYC(10), .SCAN_UNIT_CYC(10),
      .BACKOFF_CYC(3), .CHAR_CYC(5)) i_rftc_core (.*);
   rftc_radio_model i_rftc_radio_model (.*);
   initial forever #5 clk = ~clk;
   task cyc(int n);
      repeat (n) @(negedge clk);
   endtask
   task chk(logic [31:0] v, logic [31:0] e);
      comparisons++;
      if (v !== e) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, v, e);
      end
   endtask
   task wr(logic [3:0] i, logic [31:0] d);
      cfg_wr = 1; cfg_idx = i; cfg_wdata = d;
      cyc(1);
      cfg_wr = 0;
      cyc(1);
   endtask
   task rd(logic [3:0] i, logic [31:0] e);
      q_rd.push_back(e);
      cfg_rd = 1; cfg_idx = i;
      cyc(1);
      cfg_rd = 0;
      cyc(1);
   endtask
   task pkt(int n, logic [1:0] e);
      int k;
      k = 0;
      q_pkt.push_back(e);
      while (k < n) begin
         rx_byte = $urandom;
         rx_valid = 1;
         if (rx_ready) begin
            sent[k] = rx_byte;
            k++;
         end
         cyc(1);
      end
      rx_valid = 0;
      wait (q_pkt.size() == 0);
      cyc(2);
   endtask
   task meas(int n);
      h = 0;
      repeat (n) begin
         cyc(1);
         h += (pwm_out === 1'b1);
      end
   endtask
   task stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge clk) rd_seen <= cfg_rd && rst_n;
   always @(negedge clk) begin
      if (rd_seen) chk(cfg_rdata, q_rd.pop_front());
      if (tx_ok || tx_drop) chk({tx_ok, tx_drop}, q_pkt.pop_front());
   end
   initial begin
      cyc(90000);
      n_fail++;
      stop_test;
   end
   initial begin
      void'($urandom(4189));
      cyc(8);
      rst_n = 1;
      cyc(1);
      for (int i = 0; i < 10; i++) rd(i[3:0], rv[i]);
      rd(4'hF, 0);
      wr(6, 0);
      rd(6, UA[63:32]);
      for (int i = 0; i < 3; i++) begin
         wr(bi[i], bv[i]);
         rd(bi[i], rv[bi[i]]);
         wr(bi[i], gv[i]);
         rd(bi[i], gv[i]);
      end
      wr(0, 0); wr(3, 0); wr(5, 1);
      chk(low_power_allow, 0);
      wr(8, 1);
      chk(low_power_allow, 1);
      wr(8, 0);
      $display("register test done");
      pkt(3, 2'b10);
      chk(last_len, 3);
      wr(1, 8'hFF);
      pkt(100, 2'b10);
      chk(last_len, 100);
      tx_rd_addr = $urandom % 100;
      cyc(2);
      chk(tx_rd_data, sent[tx_rd_addr]);
      wr(1, 0);
      pkt(1, 2'b10);
      wr(0, 3); cca_busy = 1;
      pkt(1, 2'b01);
      cca_busy = 0; wr(0, 0); wr(9, 32'hFFFF);
      for (int r = 0; r < 3; r += 2) begin
         wr(3, r); s = n_send;
         pkt(1, 2'b10);
         chk(n_send - s, r ? r + 2 : 1);
      end
      wr(9, 1); wr(3, 1); s = n_send;
      pkt(1, 2'b01);
      chk(n_send - s, 2);
      chk(last_ack, 1);
      ack_en = 1; s = n_send;
      pkt(1, 2'b10);
      chk(n_send - s, 1);
      rf_purged = 1; s = n_send;
      pkt(1, 2'b01);
      chk(n_send - s, 1);
      rf_purged = 0;
      $display("packet test done");
      meas(200);
      chk(h, 0);
      wr(2, 8'hFF);
      for (int i = 0; i < 3; i++) begin
         s = 445 * (i == 0 ? 41 : i == 1 ? 58 : 75) / 100;
         rx_db = 10 * (i + 1); rx_pkt = 1;
         cyc(1);
         rx_pkt = 0;
         cyc(20);
         meas(6230);
         chk(h >= (s - 8) * 14 && h <= (s + 8) * 14, 1);
      end
      wr(2, 1); rx_pkt = 1;
      cyc(1);
      rx_pkt = 0;
      cyc(30);
      meas(500);
      chk(h, 0);
      $display("pwm test done");
      wr(4, 32'h6); scan_req = 1; scan_energy = 1;
      cyc(1);
      scan_req = 0; t = 0; ch = 0;
      while (!scan_done && t < 500) begin
         if (scan_busy && ch == 0) ch = scan_channel;
         t++;
         cyc(1);
      end
      chk(t >= 38 && t <= 46, 1);
      chk(ch, 8'h0C);
      chk(scan_is_energy, 1);
      reassign_network_id_option = 1; reassign_channel_option = 1; coord_start = 1;
      cyc(1);
      coord_start = 0;
      cyc(3);
      chk(scan_is_energy, 0);
      cyc(50);
      reassign_network_id_option = 0; coord_start = 1;
      cyc(1);
      coord_start = 0;
      cyc(3);
      chk(scan_is_energy, 1);
      $display("scan test done");
      stop_test;
   end
endmodule // testbench
